// File: verilog/clock_synth_upper_defs.vh
`ifndef CLOCK_SYNTH_UPPER_DEFS_VH
`define CLOCK_SYNTH_UPPER_DEFS_VH

// Register port widths
`define ADDR_W            8
`define DATA_W            8
`define IDX_W             4
`define NUM_BYTES         15

// Byte offsets of the upper control bank
`define OFS_IDENT         8'h07
`define OFS_VIDEO_EN      8'h08
`define OFS_STOP_DRIVE    8'h09
`define OFS_HOST_STOP     8'h0A
`define OFS_PROD_TEST_A   8'h0B
`define OFS_BLOCK_LEN     8'h0C
`define OFS_MFG_TEST      8'h0D
`define OFS_PROD_TEST_B   8'h0E
`define OFS_SPARE_15      8'h0F
`define OFS_SPARE_16      8'h10
`define OFS_PANEL_FREQ    8'h11
`define OFS_SPARE_18      8'h12
`define OFS_SPARE_19      8'h13
`define OFS_DRIVE         8'h14
`define OFS_PROD_TEST_C   8'h15

// Power-up values of the writable bits
`define RST_IDENT         8'h00
`define RST_VIDEO_EN      8'h03
`define RST_STOP_DRIVE    8'h25
`define RST_HOST_STOP     8'h03
`define RST_PROD_TEST_A   8'h01
`define RST_BLOCK_LEN     8'h0D
`define RST_SPARE_18      8'h06
`define RST_DRIVE         8'h6A
`define RST_ZERO          8'h00

// Writable bit masks; cleared bits are read-only
`define WM_IDENT          8'h00
`define WM_VIDEO_EN       8'h0F
`define WM_STOP_DRIVE     8'hBF
`define WM_HOST_STOP      8'h7F
`define WM_ALL            8'hFF

// Fixed read-only content
`define FIXED_VIDEO_EN    8'h10
`define FIXED_NONE        8'h00

// Field positions
`define BIT_VIDEO_EN      1
`define BIT_VIDEO_SPR_EN  0
`define BIT_BUS5_STOP     7
`define BIT_REF_DRIVE     5
`define BIT_TEST_REF_SEL  4
`define BIT_TEST_ENTRY    3
`define SWING_HI          2
`define SWING_LO          0
`define BIT_PANEL_STATUS  7
`define BIT_MGMT_STOP     1
`define BIT_HOST0_STOP    0
`define BLEN_HI           5
`define BLEN_LO           0
`define BIT_PANEL_96      2
`define BIT_DRV_48M       7
`define BIT_DRV_BUS5      4
`define BIT_DRV_BUS34     2
`define BIT_DRV_BUS02     0

`endif

// File: verilog/pin_sync3.v
`timescale 1ns/1ps
`default_nettype none

// Three-stage pin synchroniser; the output moves only when stages two and three agree
module pin_sync3 #(
	parameter RESET_LEVEL = 1'b1
) (
	input  wire clock,
	input  wire reset_b,
	input  wire pin,
	output reg  level
);

	reg stage1;
	reg stage2;
	reg stage3;

	// Stage one feeds stage two only, to keep metastability contained
	always @(posedge clock or negedge reset_b) begin
		if (!reset_b) begin
			stage1 <= RESET_LEVEL;
			stage2 <= RESET_LEVEL;
			stage3 <= RESET_LEVEL;
			level  <= RESET_LEVEL;
		end else begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3) begin
				level <= stage3; // Filters a single-cycle glitch
			end
		end
	end

endmodule // pin_sync3

`default_nettype wire

// File: verilog/clock_synth_upper_config_regs.v
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "clock_synth_upper_defs.vh"

//Behaviour
//(R1) Each video clock output is gated by its own enable bit in byte 8, both enabled at reset.
//(R2) Byte 9 bit 7 set stops free bus clock 5 while the bus halt request pin is active.
//(R3) Byte 9 bit 5 picks single (0) or double (1) reference drive, resetting to double.
//(R4) Byte 9 bit 3 enters test clock mode, where bit 4 picks tristate (0) or reference (1).
//(R5) Byte 9 bits 2:0 set the differential swing from 0.3V to 1.0V, resetting to 101.
//(R6) Byte 10 bit 1 set stops the management host clock while core halt is asserted.
//(R7) Byte 10 bit 0 set stops host clock 0 while core halt is asserted.
//(R8) Byte 12 bits 5:0 give the block read byte count, resetting to 13.
//(R9) Software programs the byte count before block reads longer than thirteen bytes.
//(R10) Software always writes 1 to byte 11 bit 0, which resets to 1.
//(R11) Software writes 0 to the test bits in bytes 14, 17 and 21, which reset to 0.
//(R12) Byte 17 bit 2 selects a 100MHz (0) or 96MHz (1) panel clock.
//(R13) Byte 20 bit 7 selects normal or high drive for the 48MHz output.
//(R14) Byte 20 bits 4, 2 and 0 select high drive for bus clock groups 5, 3-4 and 0-2.
//(R15) Byte 7 returns fixed revision and vendor codes and ignores writes.
//(R16) Software preserves reserved bits on writes and ignores their read values.
module clock_synth_upper_config_regs #(
	parameter [3:0] REVISION_CODE = 4'h2, // Arbitrary value
	parameter [3:0] VENDOR_CODE   = 4'h9  // Arbitrary value
) (
	input  wire                 clock,
	input  wire                 rst_b,
	input  wire [`ADDR_W-1:0]   reg_addr,
	input  wire [`DATA_W-1:0]   reg_wdata,
	input  wire                 reg_write,
	input  wire                 reg_read,
	output reg  [`DATA_W-1:0]   reg_rdata,
	input  wire                 bus_halt_req_b,
	input  wire                 core_halt_req_b,
	input  wire                 panel_pin_function_select,
	output wire                 video_clock_en,
	output wire                 video_clock_spread_en,
	output reg                  free_bus_clock_5_run,
	output reg                  host_clock_mgmt_run,
	output reg                  host_clock_0_run,
	output wire                 ref_drive_double,
	output wire                 test_clock_mode,
	output wire                 test_ref_on_outputs,
	output reg                  test_outputs_tristate,
	output wire [2:0]           diff_swing_select,
	output wire [5:0]           block_read_count,
	output wire                 panel_clock_96,
	output wire                 drive_48m_high,
	output wire                 drive_free_bus5_high,
	output wire                 drive_bus34_high,
	output wire                 drive_bus02_high
);

	// Reset release
	reg                         reset_meta_b;
	reg                         reset_sync_b;

	// Synchronised pin levels
	wire                        bus_halt_level_b;
	wire                        core_halt_level_b;
	wire                        panel_select_level;

	// Register bank, one byte per slot from offset 7 upward
	wire [8*`NUM_BYTES-1:0]     bank;
	wire [`IDX_W-1:0]           access_idx;
	wire                        access_hit;
	reg  [`DATA_W-1:0]          read_value;

	// Named views of the bytes that steer outputs
	wire [`DATA_W-1:0]          video_byte;
	wire [`DATA_W-1:0]          stop_byte;
	wire [`DATA_W-1:0]          host_byte;
	wire [`DATA_W-1:0]          blen_byte;
	wire [`DATA_W-1:0]          panel_byte;
	wire [`DATA_W-1:0]          drive_byte;

	// Address to slot index, valid only inside the bank
	function [`IDX_W-1:0] slot_of;
		input [`ADDR_W-1:0] addr;
		reg   [`ADDR_W-1:0] diff;
		begin
			diff = addr - `OFS_IDENT;
			slot_of = diff[`IDX_W-1:0];
		end
	endfunction

	// Address falls inside the upper bank
	function in_bank;
		input [`ADDR_W-1:0] addr;
		begin
			in_bank = (addr >= `OFS_IDENT) && (addr <= `OFS_PROD_TEST_C);
		end
	endfunction

	// Slot index back to its byte offset
	function [`ADDR_W-1:0] offset_of;
		input integer idx;
		reg   [`ADDR_W-1:0] step;
		begin
			step = idx[`ADDR_W-1:0];
			offset_of = `OFS_IDENT + step;
		end
	endfunction

	// Power-up value of each slot
	function [`DATA_W-1:0] reset_of;
		input [`ADDR_W-1:0] ofs;
		begin
			case (ofs)
				`OFS_IDENT:       reset_of = `RST_IDENT;
				`OFS_VIDEO_EN:    reset_of = `RST_VIDEO_EN;
				`OFS_STOP_DRIVE:  reset_of = `RST_STOP_DRIVE;
				`OFS_HOST_STOP:   reset_of = `RST_HOST_STOP;
				`OFS_PROD_TEST_A: reset_of = `RST_PROD_TEST_A;
				`OFS_BLOCK_LEN:   reset_of = `RST_BLOCK_LEN;
				`OFS_SPARE_18:    reset_of = `RST_SPARE_18;
				`OFS_DRIVE:       reset_of = `RST_DRIVE;
				`OFS_MFG_TEST:    reset_of = `RST_ZERO;
				`OFS_PROD_TEST_B: reset_of = `RST_ZERO;
				`OFS_SPARE_15:    reset_of = `RST_ZERO;
				`OFS_SPARE_16:    reset_of = `RST_ZERO;
				`OFS_PANEL_FREQ:  reset_of = `RST_ZERO;
				`OFS_SPARE_19:    reset_of = `RST_ZERO;
				`OFS_PROD_TEST_C: reset_of = `RST_ZERO;
				default:          reset_of = `RST_ZERO;
			endcase
		end
	endfunction

	// Which bits of each slot software may change
	function [`DATA_W-1:0] wmask_of;
		input [`ADDR_W-1:0] ofs;
		begin
			case (ofs)
				`OFS_IDENT:      wmask_of = `WM_IDENT;
				`OFS_VIDEO_EN:   wmask_of = `WM_VIDEO_EN;
				`OFS_STOP_DRIVE: wmask_of = `WM_STOP_DRIVE;
				`OFS_HOST_STOP:  wmask_of = `WM_HOST_STOP;
				`OFS_PROD_TEST_A: wmask_of = `WM_ALL;
				`OFS_BLOCK_LEN:  wmask_of = `WM_ALL;
				`OFS_MFG_TEST:   wmask_of = `WM_ALL;
				`OFS_PROD_TEST_B: wmask_of = `WM_ALL;
				`OFS_SPARE_15:   wmask_of = `WM_ALL;
				`OFS_SPARE_16:   wmask_of = `WM_ALL;
				`OFS_PANEL_FREQ: wmask_of = `WM_ALL;
				`OFS_SPARE_18:   wmask_of = `WM_ALL;
				`OFS_SPARE_19:   wmask_of = `WM_ALL;
				`OFS_DRIVE:      wmask_of = `WM_ALL;
				`OFS_PROD_TEST_C: wmask_of = `WM_ALL;
				default:         wmask_of = `WM_ALL;
			endcase
		end
	endfunction

	// Fixed read-only bits that sit beside stored bits
	function [`DATA_W-1:0] fixed_of;
		input [`ADDR_W-1:0] ofs;
		begin
			case (ofs)
				`OFS_IDENT:    fixed_of = {REVISION_CODE, VENDOR_CODE}; // R15
				`OFS_VIDEO_EN: fixed_of = `FIXED_VIDEO_EN;
				`OFS_STOP_DRIVE: fixed_of = `FIXED_NONE;
				`OFS_HOST_STOP: fixed_of = `FIXED_NONE;
				`OFS_PROD_TEST_A: fixed_of = `FIXED_NONE;
				`OFS_BLOCK_LEN: fixed_of = `FIXED_NONE;
				`OFS_MFG_TEST: fixed_of = `FIXED_NONE;
				`OFS_PROD_TEST_B: fixed_of = `FIXED_NONE;
				`OFS_SPARE_15: fixed_of = `FIXED_NONE;
				`OFS_SPARE_16: fixed_of = `FIXED_NONE;
				`OFS_PANEL_FREQ: fixed_of = `FIXED_NONE;
				`OFS_SPARE_18: fixed_of = `FIXED_NONE;
				`OFS_SPARE_19: fixed_of = `FIXED_NONE;
				`OFS_DRIVE:    fixed_of = `FIXED_NONE;
				`OFS_PROD_TEST_C: fixed_of = `FIXED_NONE;
				default:       fixed_of = `FIXED_NONE;
			endcase
		end
	endfunction

	// Reset goes low at once but leaves only on a clock edge
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			reset_meta_b <= 1'b0;
		end else begin
			reset_meta_b <= 1'b1;
		end
	end

	// Second stage; only this copy reaches the rest of the block
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			reset_sync_b <= 1'b0;
		end else begin
			reset_sync_b <= reset_meta_b;
		end
	end

	// Halt pins idle high, so they reset to the inactive level
	pin_sync3 #(
		.RESET_LEVEL (1'b1)
	) u_bus_halt_sync (
		.clock   (clock),
		.reset_b (reset_sync_b),
		.pin     (bus_halt_req_b),
		.level   (bus_halt_level_b)
	);

	pin_sync3 #(
		.RESET_LEVEL (1'b1)
	) u_core_halt_sync (
		.clock   (clock),
		.reset_b (reset_sync_b),
		.pin     (core_halt_req_b),
		.level   (core_halt_level_b)
	);

	// Strap pin, only reported back through byte 10
	pin_sync3 #(
		.RESET_LEVEL (1'b0)
	) u_panel_sel_sync (
		.clock   (clock),
		.reset_b (reset_sync_b),
		.pin     (panel_pin_function_select),
		.level   (panel_select_level)
	);

	// Decode of the shared port address
	assign access_idx = slot_of(reg_addr);
	assign access_hit = in_bank(reg_addr);

	// One storage byte per slot; read-only bits never load, so they hold reset
	genvar g;
	generate
		for (g = 0; g < `NUM_BYTES; g = g + 1) begin : gen_slot
			localparam [`ADDR_W-1:0] OFS   = offset_of(g);
			localparam [`DATA_W-1:0] RST   = reset_of(OFS);
			localparam [`DATA_W-1:0] WMASK = wmask_of(OFS);
			localparam [`IDX_W-1:0]  IDX   = slot_of(OFS);
			// Storage byte for this slot
			reg [`DATA_W-1:0] value;
			always @(posedge clock or negedge reset_sync_b) begin
				if (!reset_sync_b) begin
					value <= RST; // R10 R11
				end else if (reg_write && access_hit && (access_idx == IDX)) begin
					value <= (reg_wdata & WMASK) | (value & ~WMASK); // R15
				end
			end
			assign bank[8*g +: 8] = (value & WMASK) | fixed_of(OFS);
		end
	endgenerate

	// Read mux; byte 10 top bit carries the live strap level
	always @* begin
		read_value = `RST_ZERO;
		if (access_hit) begin
			read_value = bank[8*access_idx +: 8];
			if (reg_addr == `OFS_HOST_STOP) begin
				read_value[`BIT_PANEL_STATUS] = panel_select_level;
			end
		end
	end

	// Read data stand for exactly one cycle after the strobe
	always @(posedge clock or negedge reset_sync_b) begin
		if (!reset_sync_b) begin
			reg_rdata <= `RST_ZERO;
		end else if (reg_read) begin
			reg_rdata <= read_value;
		end else begin
			reg_rdata <= `RST_ZERO;
		end
	end

	assign video_byte = bank[8*(`OFS_VIDEO_EN - `OFS_IDENT) +: 8];
	assign stop_byte  = bank[8*(`OFS_STOP_DRIVE - `OFS_IDENT) +: 8];
	assign host_byte  = bank[8*(`OFS_HOST_STOP - `OFS_IDENT) +: 8];
	assign blen_byte  = bank[8*(`OFS_BLOCK_LEN - `OFS_IDENT) +: 8];
	assign panel_byte = bank[8*(`OFS_PANEL_FREQ - `OFS_IDENT) +: 8];
	assign drive_byte = bank[8*(`OFS_DRIVE - `OFS_IDENT) +: 8];

	// Video clock gating straight from the enable flops
	assign video_clock_en        = video_byte[`BIT_VIDEO_EN]; // R1
	assign video_clock_spread_en = video_byte[`BIT_VIDEO_SPR_EN]; // R1

	// Reference drive strength
	assign ref_drive_double    = stop_byte[`BIT_REF_DRIVE]; // R3

	// Reference on outputs only while test mode is entered
	assign test_clock_mode     = stop_byte[`BIT_TEST_ENTRY]; // R4
	assign test_ref_on_outputs = stop_byte[`BIT_TEST_ENTRY] & stop_byte[`BIT_TEST_REF_SEL]; // R4

	// Differential swing code, lowest level at all zeros
	assign diff_swing_select   = stop_byte[`SWING_HI:`SWING_LO]; // R5

	// Byte count handed to the serial block-read engine elsewhere
	assign block_read_count = blen_byte[`BLEN_HI:`BLEN_LO]; // R8

	// Panel frequency select
	assign panel_clock_96       = panel_byte[`BIT_PANEL_96]; // R12

	// 48MHz output drive
	assign drive_48m_high       = drive_byte[`BIT_DRV_48M]; // R13

	// Bus clock group drive strengths
	assign drive_free_bus5_high = drive_byte[`BIT_DRV_BUS5]; // R14
	assign drive_bus34_high     = drive_byte[`BIT_DRV_BUS34]; // R14
	assign drive_bus02_high     = drive_byte[`BIT_DRV_BUS02]; // R14

	// Stop gating is registered so a mask write and a pin edge meet cleanly;
	// the cost is one extra cycle of latency after the filtered pin level moves
	always @(posedge clock or negedge reset_sync_b) begin
		if (!reset_sync_b) begin
			free_bus_clock_5_run <= 1'b1;
		end else begin
			free_bus_clock_5_run <= ~(stop_byte[`BIT_BUS5_STOP] & ~bus_halt_level_b); // R2
		end
	end

	// Management host clock stops only when masked and core halt is low
	always @(posedge clock or negedge reset_sync_b) begin
		if (!reset_sync_b) begin
			host_clock_mgmt_run <= 1'b1;
		end else begin
			host_clock_mgmt_run <= ~(host_byte[`BIT_MGMT_STOP] & ~core_halt_level_b); // R6
		end
	end

	// Host clock 0 likewise, on its own mask bit
	always @(posedge clock or negedge reset_sync_b) begin
		if (!reset_sync_b) begin
			host_clock_0_run <= 1'b1;
		end else begin
			host_clock_0_run <= ~(host_byte[`BIT_HOST0_STOP] & ~core_halt_level_b); // R7
		end
	end

	// Tristate flag one cycle behind the test-mode bits
	always @(posedge clock or negedge reset_sync_b) begin
		if (!reset_sync_b) begin
			test_outputs_tristate <= 1'b0;
		end else begin
			test_outputs_tristate <= stop_byte[`BIT_TEST_ENTRY] & ~stop_byte[`BIT_TEST_REF_SEL]; // R4
		end
	end

endmodule // clock_synth_upper_config_regs

`default_nettype wire

// File: tb/csu_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none

// Port-level checks on the upper config bank
module csu_regs_chk #(
	parameter [3:0] REVISION_CODE = 4'h2,
	parameter [3:0] VENDOR_CODE   = 4'h9
) (
	input wire logic       clock,
	input wire logic       rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic       bus_halt_req_b,
	input wire logic       core_halt_req_b,
	input wire logic       video_clock_en,
	input wire logic       video_clock_spread_en,
	input wire logic       free_bus_clock_5_run,
	input wire logic       host_clock_mgmt_run,
	input wire logic       host_clock_0_run,
	input wire logic       ref_drive_double,
	input wire logic       test_clock_mode,
	input wire logic       test_ref_on_outputs,
	input wire logic       test_outputs_tristate,
	input wire logic [2:0] diff_swing_select,
	input wire logic [5:0] block_read_count,
	input wire logic       panel_clock_96,
	input wire logic       drive_48m_high,
	input wire logic       drive_free_bus5_high,
	input wire logic       drive_bus34_high,
	input wire logic       drive_bus02_high
);
	logic       pw, pr, m5, tq;
	logic [7:0] pa, pd;
	logic [1:0] hm;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// Last request and halt masks as software left them
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			{pw, pr, m5, tq, pa, pd} <= '0;
			hm <= 2'b11;
		end else begin
			{pw, pr, pa, pd} <= {reg_write, reg_read, reg_addr, reg_wdata};
			tq <= test_clock_mode & ~test_ref_on_outputs;
			if (reg_write && reg_addr == 8'h09) m5 <= reg_wdata[7];
			if (reg_write && reg_addr == 8'h0A) hm <= reg_wdata[1:0];
		end
	end
	a_ident_fixed: assert property (pr && pa == 8'h07 |-> reg_rdata == {REVISION_CODE, VENDOR_CODE})
		else $error("identification byte wrong");
	a_video_enables: assert property (pw && pa == 8'h08 |-> {video_clock_en, video_clock_spread_en} == pd[1:0])
		else $error("video enables wrong");
	a_stop_drive_view: assert property (pw && pa == 8'h09 |->
		{ref_drive_double, test_clock_mode, diff_swing_select} == {pd[5], pd[3], pd[2:0]})
		else $error("drive or swing view wrong");
	a_tristate_follow: assert property (test_outputs_tristate == tq)
		else $error("tristate output wrong");
	a_bus5_halted: assert property ((!bus_halt_req_b && m5 && $stable(m5))[*7] |-> !free_bus_clock_5_run)
		else $error("bus clock 5 not stopped");
	a_bus5_free: assert property ((bus_halt_req_b || !m5)[*7] |-> free_bus_clock_5_run)
		else $error("bus clock 5 stopped");
	a_host_halted: assert property ((!core_halt_req_b && $stable(hm))[*7] |->
		{host_clock_mgmt_run, host_clock_0_run} == ~hm)
		else $error("host clock stop wrong");
	a_host_free: assert property (core_halt_req_b[*7] |-> host_clock_mgmt_run && host_clock_0_run)
		else $error("host clock stopped");
	a_block_count: assert property (pw && pa == 8'h0C |-> block_read_count == pd[5:0])
		else $error("block count wrong");
	a_panel_freq: assert property (pw && pa == 8'h11 |-> panel_clock_96 == pd[2])
		else $error("panel clock select wrong");
	a_drive_bits: assert property (pw && pa == 8'h14 |-> {drive_48m_high, drive_free_bus5_high,
		drive_bus34_high, drive_bus02_high} == {pd[7], pd[4], pd[2], pd[0]})
		else $error("drive strength wrong");
	c_ident_read: cover property (pr && pa == 8'h07);
	c_bus5_stop: cover property (!free_bus_clock_5_run);
	c_tristate: cover property (test_outputs_tristate);
endmodule // csu_regs_chk

bind clock_synth_upper_config_regs csu_regs_chk #(
	.REVISION_CODE(REVISION_CODE), .VENDOR_CODE(VENDOR_CODE)) u_chk (
	.clock, .rst_b, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
	.bus_halt_req_b, .core_halt_req_b, .video_clock_en, .video_clock_spread_en,
	.free_bus_clock_5_run, .host_clock_mgmt_run, .host_clock_0_run, .ref_drive_double,
	.test_clock_mode, .test_ref_on_outputs, .test_outputs_tristate, .diff_swing_select,
	.block_read_count, .panel_clock_96, .drive_48m_high, .drive_free_bus5_high,
	.drive_bus34_high, .drive_bus02_high);

`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected %s: expected %h, seen %h", n, e, g); end end

module tb;
	localparam [7:0]   IDENT = 8'hC5; // Arbitrary codes
	localparam [119:0] RV    = {8'h00, 8'h6A, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h0D, 8'h01, 8'h03, 8'h25, 8'h13, IDENT};
	logic       clock, rst_b, reg_write, reg_read;
	logic       bus_halt_req_b, core_halt_req_b, panel_pin_function_select;
	logic [7:0] reg_addr, reg_wdata, v;
	wire  [7:0] reg_rdata;
	wire  [2:0] diff_swing_select;
	wire  [5:0] block_read_count;
	wire        video_clock_en, video_clock_spread_en, free_bus_clock_5_run;
	wire        host_clock_mgmt_run, host_clock_0_run, ref_drive_double, test_clock_mode;
	wire        test_ref_on_outputs, test_outputs_tristate, panel_clock_96, drive_48m_high;
	wire        drive_free_bus5_high, drive_bus34_high, drive_bus02_high;
	int         fail_count = 0;
	int         total_checks = 0;
	int         cycles = 0;

	clock_synth_upper_config_regs #(.REVISION_CODE(IDENT[7:4]), .VENDOR_CODE(IDENT[3:0])) dut (
		.clock, .rst_b, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.bus_halt_req_b, .core_halt_req_b, .panel_pin_function_select, .video_clock_en,
		.video_clock_spread_en, .free_bus_clock_5_run, .host_clock_mgmt_run, .host_clock_0_run,
		.ref_drive_double, .test_clock_mode, .test_ref_on_outputs, .test_outputs_tristate,
		.diff_swing_select, .block_read_count, .panel_clock_96, .drive_48m_high,
		.drive_free_bus5_high, .drive_bus34_high, .drive_bus02_high);

	// 50 MHz clock
	initial clock = 1'b0;
	always #10 clock = ~clock;

	// Hang guard, far beyond the few hundred cycles the run needs
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// One-cycle write strobe; returns just after the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
		#1;
	endtask

	// Read data is valid only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		`CHK("read data", e, reg_rdata)
	endtask

	// Read-back expected from a byte just written
	function automatic logic [7:0] exp_rb(input logic [7:0] a, input logic [7:0] d);
		case (a)
			8'h07: return IDENT;
			8'h08: return 8'h10 | (d & 8'h0F);
			8'h09: return d & 8'hBF;
			8'h0A: return {panel_pin_function_select, d[6:0]};
			default: return (a > 8'h06 && a < 8'h16) ? d : 8'h00;
		endcase
	endfunction

	// Test bits held at the only values software may write
	function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
		case (a)
			8'h0B: return d | 8'h01;
			8'h0E: return d & 8'h7F;
			8'h11: return d & 8'h3F;
			8'h15: return d & 8'hFE;
			default: return d;
		endcase
	endfunction

	// Masks set, pins pulled, runs checked, then pins released
	task automatic hp(input logic b, c, input logic [7:0] m9, ma, input logic [2:0] e);
		wr(8'h09, m9);
		wr(8'h0A, ma);
		bus_halt_req_b <= b;
		core_halt_req_b <= c;
		repeat (8) @(posedge clock);
		#1;
		`CHK("runs", e, {free_bus_clock_5_run, host_clock_mgmt_run, host_clock_0_run})
		bus_halt_req_b <= 1'b1;
		core_halt_req_b <= 1'b1;
		repeat (8) @(posedge clock);
		#1;
		`CHK("runs released", 3'h7, {free_bus_clock_5_run, host_clock_mgmt_run, host_clock_0_run})
	endtask

	initial begin
		{rst_b, reg_write, reg_read, reg_addr, reg_wdata, panel_pin_function_select} = '0;
		{bus_halt_req_b, core_halt_req_b} = 2'b11;
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		repeat (3) @(posedge clock);
		// Reset values, unmapped neighbours included
		for (int a = 6; a < 23; a++)
			rd(a[7:0], (a > 6 && a < 22) ? RV[8*(a-7) +: 8] : 8'h00);
		`CHK("reset views", 12'hF4D, {video_clock_en, video_clock_spread_en, ref_drive_double, diff_swing_select, block_read_count})
		// All ones then all zeros, each byte read straight after its write
		for (int i = 0; i < 2; i++) begin
			v = i ? 8'h00 : 8'hFF;
			for (int a = 6; a < 23; a++) begin
				wr(a[7:0], legal(a[7:0], v));
				rd(a[7:0], exp_rb(a[7:0], legal(a[7:0], v)));
			end
			`CHK("views", {10{v[0]}}, {video_clock_en, video_clock_spread_en, ref_drive_double, test_clock_mode, test_ref_on_outputs, panel_clock_96, drive_48m_high, drive_free_bus5_high, drive_bus34_high, drive_bus02_high})
			`CHK("swing and count", {v[2:0], v[5:0]}, {diff_swing_select, block_read_count})
		end
		// Every swing code while in tristate test mode
		for (int c = 0; c < 8; c++) begin
			wr(8'h09, 8'h08 | c[7:0]);
			@(posedge clock);
			#1;
			`CHK("test mode", {c[2:0], 4'b0101}, {diff_swing_select, ref_drive_double, test_clock_mode, test_ref_on_outputs, test_outputs_tristate})
		end
		// Halt pins against their masks
		hp(1'b0, 1'b1, 8'h80, 8'h00, 3'b011);
		hp(1'b0, 1'b0, 8'h00, 8'h00, 3'b111);
		hp(1'b1, 1'b0, 8'h00, 8'h02, 3'b101);
		hp(1'b1, 1'b0, 8'h00, 8'h01, 3'b110);
		// Strap level shows in the top bit of the host stop byte
		panel_pin_function_select <= 1'b1;
		repeat (6) @(posedge clock);
		rd(8'h0A, 8'h81);
		// Reset in mid-run restores the byte count
		wr(8'h0C, 8'h20);
		rst_b <= 1'b0;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		repeat (3) @(posedge clock);
		rd(8'h0C, 8'h0D);
		report_and_stop();
	end
endmodule // tb

`default_nettype wire
